// >>> logic/wdaux_pkg.sv
// Function
// - watchdog counter runs whenever slow oscillator is on
// - exact key disables reset, other value enables
// - reset disabled still yields interrupts, wakeups
// - only slow oscillator off stops watchdog counter
// - oscillator-off write ignored while reset enabled
// - enabled watchdog reset forces oscillator on
// - active mode to cpu, sleep to wakeup controller
// - reset cause flag sticky, cleared by software
// - three aux counters, selectable slow clock
// - counters a, b 16-bit, wrap after 65535
// - clear-on-match returns counter to zero
// - clear select bit: one match, zero free
// - new match applies after three input clocks
// - irq on match or overflow sets flag
// - no new irq while flag still set
// - flags ORed into one request, individually readable
// - enable takes effect after three input clocks
// - software avoids config writes once counters run
// - counts readable, zero bit clears counter
// - counter c 32-bit, free-running only
// - counter c irq on selected bit toggle
// - chain bits cascade a to b to c
package wdaux_pkg;
    localparam int ADDR_W = 4;
    localparam logic [31:0] DISABLE_KEY = 32'hACED8865;
    // device register indices
    localparam logic [3:0] IX_KEY = 4'h0;
    localparam logic [3:0] IX_OSC = 4'h1;
    localparam logic [3:0] IX_CAUSE = 4'h2;
    localparam logic [3:0] IX_CLKSEL = 4'h3;
    localparam logic [3:0] IX_MATCH = 4'h4;
    localparam logic [3:0] IX_CFG = 4'h5;
    localparam logic [3:0] IX_CTRL = 4'h6;
    localparam logic [3:0] IX_CNTLO = 4'h7;
    localparam logic [3:0] IX_CNTHI = 4'h8;
    localparam logic [3:0] IX_WDSTAT = 4'h9;
    // config fields; counter b fields sit CFG_B_OFS above counter a
    localparam int CFG_SEL = 0;
    localparam int CFG_CLR = 1;
    localparam int CFG_CHAIN = 2;
    localparam int CFG_B_OFS = 8;
    localparam int CFG_TOG_LSB = 16;
    localparam int TOG_W = 5;
    // control fields
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_ZERO_LSB = 4;
    localparam int CTRL_FLAG_LSB = 8;
    localparam int WDSTAT_FLAG = 16;
    localparam logic [1:0] APPLY_TICKS = 2'h3;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;
    typedef enum logic [1:0] {
        WDAUX_PM_ACTIVE = 2'b00,
        WDAUX_PM_SLEEP = 2'b01,
        WDAUX_PM_DEEP = 2'b10
    } wdaux_pm_e;
    // controller APB byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam int CMD_WE = 8;
    localparam int CMD_GO = 31;
    typedef enum logic [0:0] {
        WDAUX_IDLE = 1'b0,
        WDAUX_WAIT = 1'b1
    } wdaux_st_e;
endpackage

// >>> logic/wdaux_if.sv
`timescale 1ns/100ps
interface wdaux_if;
    logic req;
    logic we;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic [1:0] pm;
    logic cpu_irq;
    logic wic_irq;
    logic rst_req;
    modport dev (
        input req, we, addr, wdata, pm,
        output rdata, ack, cpu_irq, wic_irq, rst_req
    );
    modport ctl (
        output req, we, addr, wdata, pm,
        input rdata, ack, cpu_irq, wic_irq, rst_req
    );
endinterface

// >>> logic/wdaux_dev.sv
`timescale 1ns/100ps
module wdaux_dev (
    // clock and reset (power-on, brownout, external pin)
    input wire logic pclk,
    input wire logic presetn,
    // register port toward the controller
    wdaux_if.dev bus,
    // slow clock pins, asynchronous
    input wire logic lso_clk_in,
    input wire logic wco_clk_in,
    // expiry from the base watchdog match logic
    input wire logic wdt_bite
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] lso_s;
        logic [2:0] wco_s;
        logic key_dis;
        logic osc_en;
        logic cause;
        logic wd_flag;
        logic [15:0] wd_cnt;
        logic clk_sel;
        logic [31:0] match_eff;
        logic [31:0] match_pend;
        logic [1:0] match_dly;
        logic [31:0] cfg;
        logic [2:0] run;
        logic [2:0] run_pend;
        logic [1:0] run_dly;
        logic [1:0][15:0] cnt_ab;
        logic [31:0] cnt_c;
        logic [2:0] flags;
        logic ack;
        logic [31:0] rdata;
        logic cpu_irq;
        logic wic_irq;
        logic rst_req;
    } wdaux_dev_s;

    localparam int TOG_W = wdaux_pkg::TOG_W;

    wdaux_dev_s q, d;
    logic lso_tick, wco_tick, aux_tick, step_c, tog;
    logic [1:0] step, hit, ovf;
    logic [31:0] c_next;
    logic [TOG_W-1:0] tsel;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.ack = 1'b0;
        // first stage feeds only the second
        d.lso_s = {q.lso_s[1:0], lso_clk_in};
        d.wco_s = {q.wco_s[1:0], wco_clk_in};
        lso_tick = q.lso_s[1] & ~q.lso_s[2] & q.osc_en;
        wco_tick = q.wco_s[1] & ~q.wco_s[2];
        aux_tick = q.clk_sel ? wco_tick : lso_tick;
        tsel = q.cfg[wdaux_pkg::CFG_TOG_LSB +: TOG_W];

        // register access: clears first so hardware sets below win
        if (bus.req && !q.ack) begin
            d.ack = 1'b1;
            if (bus.we) begin
                if (bus.addr == wdaux_pkg::IX_KEY) begin
                    d.key_dis = (bus.wdata == wdaux_pkg::DISABLE_KEY);
                end else if (bus.addr == wdaux_pkg::IX_OSC) begin
                    if (bus.wdata[0] || q.key_dis) begin
                        d.osc_en = bus.wdata[0];
                    end
                end else if (bus.addr == wdaux_pkg::IX_CAUSE) begin
                    if (bus.wdata[0]) begin
                        d.cause = 1'b0;
                    end
                end else if (bus.addr == wdaux_pkg::IX_CLKSEL) begin
                    d.clk_sel = bus.wdata[0];
                end else if (bus.addr == wdaux_pkg::IX_MATCH) begin
                    d.match_pend = bus.wdata;
                    d.match_dly = wdaux_pkg::APPLY_TICKS;
                end else if (bus.addr == wdaux_pkg::IX_CFG) begin
                    d.cfg = bus.wdata;
                end else if (bus.addr == wdaux_pkg::IX_CTRL) begin
                    d.run_pend = bus.wdata[wdaux_pkg::CTRL_RUN_LSB +: 3];
                    d.run_dly = wdaux_pkg::APPLY_TICKS;
                    d.flags = q.flags & ~bus.wdata[wdaux_pkg::CTRL_FLAG_LSB +: 3];
                end else if (bus.addr == wdaux_pkg::IX_WDSTAT) begin
                    if (bus.wdata[wdaux_pkg::WDSTAT_FLAG]) begin
                        d.wd_flag = 1'b0;
                    end
                end
            end else begin
                d.rdata = 32'h0;
                if (bus.addr == wdaux_pkg::IX_KEY) begin
                    d.rdata = {31'h0, q.key_dis};
                end else if (bus.addr == wdaux_pkg::IX_OSC) begin
                    d.rdata = {31'h0, q.osc_en};
                end else if (bus.addr == wdaux_pkg::IX_CAUSE) begin
                    d.rdata = {31'h0, q.cause};
                end else if (bus.addr == wdaux_pkg::IX_CLKSEL) begin
                    d.rdata = {31'h0, q.clk_sel};
                end else if (bus.addr == wdaux_pkg::IX_MATCH) begin
                    d.rdata = q.match_pend;
                end else if (bus.addr == wdaux_pkg::IX_CFG) begin
                    d.rdata = q.cfg;
                end else if (bus.addr == wdaux_pkg::IX_CTRL) begin
                    d.rdata = {21'h0, q.flags, 5'h0, q.run};
                end else if (bus.addr == wdaux_pkg::IX_CNTLO) begin
                    d.rdata = {q.cnt_ab[1], q.cnt_ab[0]};
                end else if (bus.addr == wdaux_pkg::IX_CNTHI) begin
                    d.rdata = q.cnt_c;
                end else if (bus.addr == wdaux_pkg::IX_WDSTAT) begin
                    d.rdata = {15'h0, q.wd_flag, q.wd_cnt};
                end
            end
        end

        // watchdog counter: free-running on the slow oscillator only
        if (lso_tick) begin
            d.wd_cnt = q.wd_cnt + 16'h1;
            if (q.wd_cnt == wdaux_pkg::CNT16_MAX) begin
                d.wd_flag = 1'b1;
            end
        end
        if (!q.key_dis) begin
            d.osc_en = 1'b1;
        end
        // reset cause holds until software clears it or presetn, which is a full restart
        if (wdt_bite && !q.key_dis) begin
            d.rst_req = 1'b1;
            d.cause = 1'b1;
        end

        // settings cross into the counters after three input clocks
        if (aux_tick && q.match_dly != 2'h0) begin
            d.match_dly = q.match_dly - 2'h1;
            if (q.match_dly == 2'h1) begin
                d.match_eff = q.match_pend;
            end
        end
        if (aux_tick && q.run_dly != 2'h0) begin
            d.run_dly = q.run_dly - 2'h1;
            if (q.run_dly == 2'h1) begin
                d.run = q.run_pend;
            end
        end

        // counters a and b; b may step on a's match instead of the clock
        for (int i = 0; i < 2; i++) begin
            step[i] = aux_tick & q.run[i];
            if (i == 1 && q.cfg[wdaux_pkg::CFG_CHAIN]) begin
                step[i] = step[i] & hit[0];
            end
            hit[i] = step[i] & (q.cnt_ab[i] == q.match_eff[16*i +: 16]);
            ovf[i] = step[i] & (q.cnt_ab[i] == wdaux_pkg::CNT16_MAX);
            if (step[i]) begin
                if (hit[i] && q.cfg[wdaux_pkg::CFG_B_OFS*i + wdaux_pkg::CFG_CLR]) begin
                    d.cnt_ab[i] = 16'h0;
                end else begin
                    d.cnt_ab[i] = q.cnt_ab[i] + 16'h1;
                end
            end
            // a flag already set swallows further events
            if (q.cfg[wdaux_pkg::CFG_B_OFS*i + wdaux_pkg::CFG_SEL] ? ovf[i] : hit[i]) begin
                d.flags[i] = 1'b1;
            end
        end

        // counter c: 32-bit free-running, irq on selected bit toggle
        step_c = aux_tick & q.run[2];
        if (q.cfg[wdaux_pkg::CFG_B_OFS + wdaux_pkg::CFG_CHAIN]) begin
            step_c = step_c & hit[1];
        end
        c_next = q.cnt_c + 32'h1;
        tog = c_next[tsel] ^ q.cnt_c[tsel];
        if (step_c) begin
            d.cnt_c = c_next;
            if (tog) begin
                d.flags[2] = 1'b1;
            end
        end

        // zero bits win over counting in the same cycle
        if (bus.req && !q.ack && bus.we && bus.addr == wdaux_pkg::IX_CTRL) begin
            for (int i = 0; i < 2; i++) begin
                if (bus.wdata[wdaux_pkg::CTRL_ZERO_LSB + i]) begin
                    d.cnt_ab[i] = 16'h0;
                end
            end
            if (bus.wdata[wdaux_pkg::CTRL_ZERO_LSB + 2]) begin
                d.cnt_c = 32'h0;
            end
        end

        // one request, steered by power mode
        d.cpu_irq = (d.wd_flag | (|d.flags))
            & (bus.pm == wdaux_pkg::WDAUX_PM_ACTIVE);
        d.wic_irq = (d.wd_flag | (|d.flags))
            & (bus.pm != wdaux_pkg::WDAUX_PM_ACTIVE);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.osc_en <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.rdata = q.rdata;
    assign bus.ack = q.ack;
    assign bus.cpu_irq = q.cpu_irq;
    assign bus.wic_irq = q.wic_irq;
    assign bus.rst_req = q.rst_req;
endmodule // wdaux_dev

// >>> logic/wdaux_ctl.sv
`timescale 1ns/100ps
module wdaux_ctl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // device side
    wdaux_if.ctl dev
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        wdaux_pkg::wdaux_st_e st;
        logic req;
        logic we;
        logic [3:0] addr;
        logic [31:0] wdata;
        logic [1:0] pm;
        logic [31:0] rdata;
        logic done;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } wdaux_ctl_s;

    wdaux_ctl_s q, d;
    logic setup, commit, busy, mapped;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        busy = (q.st == wdaux_pkg::WDAUX_WAIT);
        setup = psel & ~penable;
        commit = psel & penable & q.pready;
        mapped = (paddr == wdaux_pkg::OFS_CMD) || (paddr == wdaux_pkg::OFS_WDATA)
            || (paddr == wdaux_pkg::OFS_MODE) || (paddr == wdaux_pkg::OFS_STATUS)
            || (paddr == wdaux_pkg::OFS_RDATA);
        // no wait state: answer always in the first access cycle
        d.pready = setup;
        if (setup) begin
            d.pslverr = ~mapped;
            d.prdata = 32'h0;
            if (paddr == wdaux_pkg::OFS_CMD) begin
                d.prdata = {23'h0, q.we, 4'h0, q.addr};
            end else if (paddr == wdaux_pkg::OFS_WDATA) begin
                d.prdata = q.wdata;
            end else if (paddr == wdaux_pkg::OFS_MODE) begin
                d.prdata = {30'h0, q.pm};
            end else if (paddr == wdaux_pkg::OFS_STATUS) begin
                d.prdata = {27'h0, dev.rst_req, dev.wic_irq, dev.cpu_irq, q.done, busy};
            end else if (paddr == wdaux_pkg::OFS_RDATA) begin
                d.prdata = q.rdata;
            end
        end else if (commit) begin
            d.pslverr = 1'b0;
        end
        // command and data are frozen while a device access is open
        if (commit && pwrite && !busy) begin
            if (paddr == wdaux_pkg::OFS_CMD) begin
                d.addr = pwdata[3:0];
                d.we = pwdata[wdaux_pkg::CMD_WE];
                if (pwdata[wdaux_pkg::CMD_GO]) begin
                    d.req = 1'b1;
                    d.done = 1'b0;
                    d.st = wdaux_pkg::WDAUX_WAIT;
                end
            end else if (paddr == wdaux_pkg::OFS_WDATA) begin
                d.wdata = pwdata;
            end
        end
        if (commit && pwrite && paddr == wdaux_pkg::OFS_MODE) begin
            d.pm = pwdata[1:0];
        end
        case (q.st)
            wdaux_pkg::WDAUX_IDLE: begin
            end
            wdaux_pkg::WDAUX_WAIT: begin
                if (dev.ack) begin
                    d.req = 1'b0;
                    d.rdata = dev.rdata;
                    d.done = 1'b1;
                    d.st = wdaux_pkg::WDAUX_IDLE;
                end
            end
            default: d.st = wdaux_pkg::WDAUX_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign dev.req = q.req;
    assign dev.we = q.we;
    assign dev.addr = q.addr;
    assign dev.wdata = q.wdata;
    assign dev.pm = q.pm;
endmodule // wdaux_ctl

// >>> sim/wdaux_checker.sv
`timescale 1ns/100ps
module wdaux_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link between controller and device
    input wire logic req,
    input wire logic we,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic [1:0] pm,
    input wire logic cpu_irq,
    input wire logic wic_irq,
    input wire logic rst_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // key state mirror; updated one cycle after the device takes the write
    logic key_off_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_off_q <= 1'b0;
        end else if (ack && we && addr == wdaux_pkg::IX_KEY) begin
            key_off_q <= (wdata == wdaux_pkg::DISABLE_KEY);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_follows_req: assert property ($rose(req) |=> ack)
        else $error("device did not answer the request");
    a_cpu_when_active: assert property (
        cpu_irq && $stable(pm) && $past(pm) == $past(pm, 2) |-> pm == wdaux_pkg::WDAUX_PM_ACTIVE)
        else $error("cpu request outside active mode");
    a_wic_when_asleep: assert property (
        wic_irq && $stable(pm) && $past(pm) == $past(pm, 2) |-> pm != wdaux_pkg::WDAUX_PM_ACTIVE)
        else $error("wakeup request in active mode");
    a_reset_req_sticky: assert property (rst_req |=> rst_req)
        else $error("reset request dropped");
    a_irq_held_set: assert property (
        $fell(cpu_irq || wic_irq) |-> $past(req) || $past(req, 2) || $past(req, 3))
        else $error("interrupt dropped without a clear");
    a_key_readback: assert property (
        ack && !we && addr == wdaux_pkg::IX_KEY |-> rdata[0] == key_off_q)
        else $error("key state read back wrong");
    a_osc_forced_on: assert property (
        ack && !we && addr == wdaux_pkg::IX_OSC && !key_off_q |-> rdata[0])
        else $error("slow oscillator off while reset enabled");
    a_flag_gives_irq: assert property (
        ack && !we && addr == wdaux_pkg::IX_CTRL && rdata[10:8] != 3'h0
        |-> ##[0:2] (cpu_irq || wic_irq))
        else $error("flag set without interrupt request");
    a_no_reset_disabled: assert property ($rose(rst_req) |-> !key_off_q)
        else $error("reset request while reset disabled");
endmodule // wdaux_checker

// >>> sim/watchdog_and_aux_timers_tb.sv
`timescale 1ns/100ps
module watchdog_and_aux_timers_tb;
    typedef struct {logic [3:0] widx; logic [31:0] wd; logic [3:0] ridx; logic [31:0] exp;} wdaux_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lso, watch_crystal_osc, bite, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, rd0;
    logic [3:0] div = 4'h0;
    int fails = 0;
    int n_tests = 0;
    // key, oscillator enable: each row writes one place and reads bit 0 of one place
    wdaux_row_s rows [5] = '{'{4'h0, 32'h0, 4'h0, 32'h0}, '{4'h1, 32'h0, 4'h1, 32'h1},
        '{4'h0, 32'hACED8865, 4'h0, 32'h1}, '{4'h1, 32'h0, 4'h1, 32'h0},
        '{4'h0, 32'h12345678, 4'h1, 32'h1}};
    wdaux_if bus_if();
    wdaux_dev wdaux_dev_i (.pclk(pclk), .presetn(presetn), .bus(bus_if), .lso_clk_in(lso),
        .wco_clk_in(watch_crystal_osc), .wdt_bite(bite));
    wdaux_ctl wdaux_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .dev(bus_if));
    wdaux_checker wdaux_checker_i (.pclk(pclk), .presetn(presetn), .req(bus_if.req),
        .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .ack(bus_if.ack), .pm(bus_if.pm), .cpu_irq(bus_if.cpu_irq), .wic_irq(bus_if.wic_irq),
        .rst_req(bus_if.rst_req));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // slow oscillator at one eighth, watch crystal at one sixteenth of pclk
    always @(posedge pclk) begin
        div <= div + 4'h1;
        lso <= div[2];
        watch_crystal_osc <= div[3];
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            fails++;
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one device access through the controller; waits for done with busy low
    task automatic dacc(input logic wr, input logic [3:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h0;
        // write answers carry stale read-back, so they must not seed the poll
        apb(1'b1, wdaux_pkg::OFS_WDATA, d, q);
        apb(1'b1, wdaux_pkg::OFS_CMD, {1'b1, 22'h0, wr, 4'h0, idx}, q);
        while (s[1:0] !== 2'b10 && n < 20) begin
            apb(1'b0, wdaux_pkg::OFS_STATUS, 32'h0, s);
            n++;
        end
        if (s[1:0] !== 2'b10) begin
            fails++;
        end
        apb(1'b0, wdaux_pkg::OFS_RDATA, 32'h0, q);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic bite_pulse();
        bite <= 1'b1;
        @(posedge pclk);
        bite <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bite = 1'b0;
        do_reset();
        foreach (rows[i]) begin
            dacc(1'b1, rows[i].widx, rows[i].wd, rd);
            dacc(1'b0, rows[i].ridx, 32'h0, rd);
            chk("row_bit0", rows[i].exp, rd & 32'h1);
        end
        $display("test table done");
        dacc(1'b1, wdaux_pkg::IX_KEY, wdaux_pkg::DISABLE_KEY, rd);
        bite_pulse();
        chk("bite_masked", 32'h0, {31'h0, bus_if.rst_req});
        dacc(1'b1, wdaux_pkg::IX_KEY, 32'h0, rd);
        bite_pulse();
        chk("bite_reset", 32'h1, {31'h0, bus_if.rst_req});
        dacc(1'b0, wdaux_pkg::IX_CAUSE, 32'h0, rd);
        chk("cause_set", 32'h1, rd & 32'h1);
        dacc(1'b1, wdaux_pkg::IX_CAUSE, 32'h1, rd);
        dacc(1'b0, wdaux_pkg::IX_CAUSE, 32'h0, rd);
        chk("cause_clear", 32'h0, rd & 32'h1);
        do_reset();
        chk("rst_req_reset", 32'h0, {31'h0, bus_if.rst_req});
        dacc(1'b0, wdaux_pkg::IX_CTRL, 32'h0, rd);
        chk("ctrl_reset", 32'h0, rd);
        dacc(1'b0, wdaux_pkg::IX_CNTLO, 32'h0, rd);
        chk("cntlo_reset", 32'h0, rd);
        dacc(1'b0, wdaux_pkg::IX_WDSTAT, 32'h0, rd0);
        dacc(1'b0, wdaux_pkg::IX_WDSTAT, 32'h0, rd);
        chk("wd_running", 32'h1, {31'h0, rd[15:0] !== rd0[15:0]});
        apb(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped_err", 32'h1, {31'h0, last_err});
        $display("test reset done");
        // counter a, clear on match at 3, flag on match
        dacc(1'b1, wdaux_pkg::IX_CLKSEL, 32'h0, rd);
        dacc(1'b1, wdaux_pkg::IX_MATCH, 32'h3, rd);
        dacc(1'b1, wdaux_pkg::IX_CFG, 32'h2, rd);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h1, rd);
        repeat (96) @(posedge pclk);
        dacc(1'b0, wdaux_pkg::IX_CNTLO, 32'h0, rd);
        chk("cnt_a_bound", 32'h1, {31'h0, rd[15:0] <= 16'h0003});
        dacc(1'b0, wdaux_pkg::IX_CTRL, 32'h0, rd);
        chk("flag_a_match", 32'h100, rd & 32'h700);
        chk("cpu_irq_on", 32'h1, {31'h0, bus_if.cpu_irq});
        apb(1'b1, wdaux_pkg::OFS_MODE, 32'h1, rd);
        repeat (4) @(posedge pclk);
        chk("wic_irq_sleep", 32'h2, {30'h0, bus_if.wic_irq, bus_if.cpu_irq});
        apb(1'b1, wdaux_pkg::OFS_MODE, 32'h0, rd);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h0, rd);
        repeat (48) @(posedge pclk);
        chk("irq_held", 32'h1, {31'h0, bus_if.cpu_irq});
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h10, rd);
        dacc(1'b0, wdaux_pkg::IX_CNTLO, 32'h0, rd);
        chk("cnt_a_zeroed", 32'h0, {16'h0, rd[15:0]});
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h100, rd);
        repeat (4) @(posedge pclk);
        chk("irq_cleared", 32'h0, {31'h0, bus_if.cpu_irq});
        $display("test match done");
        // free running with flag on overflow only: passing the match sets nothing
        dacc(1'b1, wdaux_pkg::IX_CFG, 32'h1, rd);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h1, rd);
        repeat (96) @(posedge pclk);
        dacc(1'b0, wdaux_pkg::IX_CNTLO, 32'h0, rd);
        chk("cnt_a_free", 32'h1, {31'h0, rd[15:0] > 16'h0003});
        dacc(1'b0, wdaux_pkg::IX_CTRL, 32'h0, rd);
        chk("no_flag_overflow", 32'h0, rd & 32'h700);
        // chain a into b with a clearing at 1: b steps at half the rate
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h0, rd);
        repeat (32) @(posedge pclk);
        dacc(1'b1, wdaux_pkg::IX_MATCH, 32'h1, rd);
        dacc(1'b1, wdaux_pkg::IX_CFG, 32'h6, rd);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h33, rd);
        repeat (96) @(posedge pclk);
        dacc(1'b0, wdaux_pkg::IX_CNTLO, 32'h0, rd);
        chk("cascade_b", 32'h1, {31'h0, rd[31:16] > 16'h0 && rd[31:16] <= 16'h8});
        $display("test free and chain done");
        // counter c with toggle select 0: flag on every tick
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h0, rd);
        repeat (32) @(posedge pclk);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h700, rd);
        dacc(1'b1, wdaux_pkg::IX_CFG, 32'h0, rd);
        // watch crystal ticks at half the slow oscillator rate here
        dacc(1'b1, wdaux_pkg::IX_CLKSEL, 32'h1, rd);
        dacc(1'b1, wdaux_pkg::IX_CTRL, 32'h4, rd);
        repeat (96) @(posedge pclk);
        dacc(1'b0, wdaux_pkg::IX_CTRL, 32'h0, rd);
        chk("flag_c_toggle", 32'h400, rd & 32'h400);
        dacc(1'b0, wdaux_pkg::IX_CNTHI, 32'h0, rd);
        chk("cnt_c_runs", 32'h1, {31'h0, rd > 32'h0 && rd <= 32'h8});
        $display("test counter c done");
        end_of_test();
    end
endmodule // watchdog_and_aux_timers_tb
